// ==== rtl/tcr_defines.vh ====
// Constants for the transmit and hardware configuration register bank.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef TCR_DEFINES_VH
`define TCR_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TCR_ADDR_TX_CFG 8'h70
`define TCR_ADDR_HARDWARE_CONFIG 8'h74

// ----------------------------------------------------------------------
// Transmit configuration fields
// ----------------------------------------------------------------------
`define TCR_TX_STS_DISCARD 15
`define TCR_TX_DAT_DISCARD 14
`define TCR_TX_OVR_ALLOW 2
`define TCR_TX_ENABLE 1
`define TCR_TX_STOP 0

// ----------------------------------------------------------------------
// Hardware configuration fields
// ----------------------------------------------------------------------
`define TCR_HW_PORT_END 29
`define TCR_HW_DIR_END 28
`define TCR_HW_XOVER 24
`define TCR_HW_MBO 20
`define TCR_HW_SIZE_LO 16
`define TCR_HW_SIZE_HI 19
`define TCR_HW_RST_TO 1
`define TCR_HW_SOFTWARE_RESET_BIT 0

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define TCR_SIZE_RESET 4'h5
`define TCR_SIZE_MIN 4'h2
`define TCR_SIZE_MAX 4'he
`define TCR_TOTAL_BYTES 15'h4000
`define TCR_STS_BYTES 15'h0200
`define TCR_KB_SHIFT 10

// ----------------------------------------------------------------------
// Timing: soft reset timeout in ns, turned into cycles at 100 ns per clock; duration in cycles
// ----------------------------------------------------------------------
`define TCR_CLK_NS 100
`define TCR_RESET_TIMEOUT_FLAG_NS 1000000
`define TCR_RESET_TIMEOUT_FLAG_CYC ((`TCR_RESET_TIMEOUT_FLAG_NS) / (`TCR_CLK_NS))
`define TCR_SOFTWARE_RESET_BIT_RUN_CYC 16

`endif

// ==== rtl/tcr_soft_reset.v ====
// Soft reset sequencer: runs a reset pulse while the link clocks are alive.
// Assumes a synchronous clocks_ok level from the PHY clock monitor.
`include "tcr_defines.vh"

module tcr_soft_reset #(
    parameter TIMEOUT_CYC = `TCR_RESET_TIMEOUT_FLAG_CYC,
    parameter RUN_CYC = `TCR_SOFTWARE_RESET_BIT_RUN_CYC
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire clocks_ok,
    output reg busy_reg,
    output reg soft_rst_reg,
    output reg timeout_reg
);

    reg [19:0] cnt_reg;
    reg waiting_reg;

    // Wait for clocks up to the timeout, then pulse the reset or give up.
    always @(posedge clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            soft_rst_reg <= 1'b0;
            timeout_reg <= 1'b0;
            cnt_reg <= 20'h0_0000;
            waiting_reg <= 1'b0;
        end else begin
            soft_rst_reg <= 1'b0;
            if (start && !busy_reg) begin
                busy_reg <= 1'b1;
                waiting_reg <= 1'b1;
                timeout_reg <= 1'b0;
                cnt_reg <= 20'h0_0000;
            end else if (busy_reg && waiting_reg) begin
                // [RULE_19] Timeout without clocks.
                if (clocks_ok) begin
                    waiting_reg <= 1'b0;
                    cnt_reg <= 20'h0_0000;
                end else if (cnt_reg == TIMEOUT_CYC[19:0] - 20'h0_0001) begin
                    busy_reg <= 1'b0;
                    waiting_reg <= 1'b0;
                    timeout_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 20'h0_0001;
                end
            end else if (busy_reg) begin
                // [RULE_18] Reset pulse then clear.
                soft_rst_reg <= 1'b1;
                // The pulse stays up through this last edge, so it lasts RUN_CYC cycles.
                if (cnt_reg == RUN_CYC[19:0] - 20'h0_0001) begin
                    busy_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg + 20'h0_0001;
                end
            end
        end
    end

endmodule

// ==== rtl/tcr_regs.v ====
// Transmit and hardware configuration register bank.
// Assumes a one-cycle strobe register port, and that the transmit engine
// reports frame activity and status FIFO fill synchronously to clk.
//
// Design decision made here: strobed register access.
`include "tcr_defines.vh"

//Contract
// [RULE_01] Status discard zeroes status pointers, self-clears
// [RULE_02] Data discard zeroes data pointers, self-clears
// [RULE_03] Full status FIFO suspends unless overrun allowed
// [RULE_04] Status full interrupt ignores overrun setting
// [RULE_05] Enable transmits queued data, resets zero
// [RULE_06] Enable clears after stop and halt
// [RULE_07] Stop finishes frame, halts, then clears
// [RULE_08] Writes to stop ignored while set
// [RULE_09] Host stops traffic before hardware config write
// [RULE_10] Port endian bit orders port accesses
// [RULE_11] Direct endian bit orders direct accesses
// [RULE_12] Endian bits survive soft reset
// [RULE_13] Read-only bit shows sampled crossover strap
// [RULE_14] Host must write must-be-one bit
// [RULE_15] Size field sets transmit space, 1KB steps
// [RULE_16] Status FIFO takes 512 bytes of allocation
// [RULE_17] Receive space is 16KB minus transmit
// [RULE_18] Soft reset bit starts reset, self-clears
// [RULE_19] Soft reset times out without PHY clocks
// [RULE_20] Host fixes cause then retries reset
// [RULE_21] Reserved bits read zero, writes ignored
module tcr_regs #(
    parameter SOFTWARE_RESET_BIT_TIMEOUT_CYC = `TCR_RESET_TIMEOUT_FLAG_CYC
) (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata_reg,
    input wire auto_crossover_strap,
    input wire phy_clocks_ok,
    input wire frame_active,
    input wire tx_status_full,
    input wire direct_fifo_sel,
    output wire tx_status_ptr_clear,
    output wire tx_data_ptr_clear,
    output wire tx_run,
    output wire tx_status_full_irq,
    output wire fifo_big_endian,
    output reg [14:0] tx_alloc_bytes_reg,
    output reg [14:0] tx_data_bytes_reg,
    output reg [14:0] rx_alloc_bytes_reg,
    output wire soft_reset_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_STOPPING = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg tx_enable_reg;
    reg tx_stop_reg;
    reg status_overrun_allow_reg;
    reg tx_sts_discard_reg;
    reg tx_dat_discard_reg;
    reg port_endian_select_reg;
    reg direct_endian_select_reg;
    reg must_be_one_reg;
    reg [3:0] tx_alloc_size_reg;
    reg auto_crossover_reg;
    reg strap_taken_reg;
    wire wr_tx;
    wire wr_hw;
    wire software_reset_bit_busy;
    wire software_reset_bit_pulse;
    wire reset_timeout_flag;
    wire regs_rst;
    wire halted;
    wire stop_done;
    wire [3:0] size_field;
    wire [14:0] alloc_bytes;

    // Register decode and the combined hard or soft reset.
    assign wr_tx = wr_stb && (addr == `TCR_ADDR_TX_CFG);
    assign wr_hw = wr_stb && (addr == `TCR_ADDR_HARDWARE_CONFIG);
    assign regs_rst = rst || software_reset_bit_pulse;
    // Size field of a hardware configuration write, checked before use.
    assign size_field = wdata[`TCR_HW_SIZE_HI:`TCR_HW_SIZE_LO];

    // ------------------------------------------------------------------
    // Soft reset sequencer
    // ------------------------------------------------------------------
    tcr_soft_reset #(
        .TIMEOUT_CYC(SOFTWARE_RESET_BIT_TIMEOUT_CYC),
        .RUN_CYC(`TCR_SOFTWARE_RESET_BIT_RUN_CYC)
    ) u_software_reset_bit (
        .clk(clk),
        .rst(rst),
        .start(wr_hw && wdata[`TCR_HW_SOFTWARE_RESET_BIT]),
        .clocks_ok(phy_clocks_ok),
        .busy_reg(software_reset_bit_busy),
        .soft_rst_reg(software_reset_bit_pulse),
        .timeout_reg(reset_timeout_flag)
    );
    assign soft_reset_out = software_reset_bit_pulse;

    // ------------------------------------------------------------------
    // Transmit engine gate
    // ------------------------------------------------------------------
    // Halted when no frame is on the wire in the stopping state.
    assign halted = (state_reg == ST_STOPPING) && !frame_active;
    // A stop request is done once halted, or at once if already idle.
    // Enable and stop must fall together, else an idle enable would start
    // the transmitter again right after the stop was honoured.
    assign stop_done = tx_stop_reg && (halted || state_reg == ST_IDLE);
    // A full status FIFO holds off only new frames, never one on the wire,
    // and while stopping only the frame already started may go on.
    // [RULE_03] Suspend on full status.
    // [RULE_07] Stop ends after frame.
    assign tx_run = ((state_reg == ST_RUN) &&
                     (status_overrun_allow_reg || !tx_status_full || frame_active)) ||
                    ((state_reg == ST_STOPPING) && frame_active);
    // [RULE_04] Interrupt independent of allowance.
    assign tx_status_full_irq = tx_status_full;
    // [RULE_01] Status pointer clear.
    assign tx_status_ptr_clear = tx_sts_discard_reg;
    // [RULE_02] Data pointer clear.
    assign tx_data_ptr_clear = tx_dat_discard_reg;
    // [RULE_10] Port path order.
    // [RULE_11] Direct path order.
    assign fifo_big_endian = direct_fifo_sel ? direct_endian_select_reg
                                             : port_endian_select_reg;

    // Transmitter state selection.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (tx_enable_reg && !tx_stop_reg) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (tx_stop_reg) begin
                    state_next = ST_STOPPING;
                end else if (!tx_enable_reg) begin
                    state_next = ST_IDLE;
                end
            end
            ST_STOPPING: begin
                if (!frame_active) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Transmit configuration register
    // ------------------------------------------------------------------
    // Transmitter state; a soft reset drops it back to idle like a hard one.
    always @(posedge clk) begin
        if (regs_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Discard bits never store: each write with the bit set gives one pulse,
    // so the bit always reads back as zero and cannot fire twice.
    // [RULE_01] Status discard pulse.
    // [RULE_02] Data discard pulse.
    always @(posedge clk) begin
        if (regs_rst) begin
            tx_sts_discard_reg <= 1'b0;
            tx_dat_discard_reg <= 1'b0;
        end else begin
            tx_sts_discard_reg <= wr_tx && wdata[`TCR_TX_STS_DISCARD];
            tx_dat_discard_reg <= wr_tx && wdata[`TCR_TX_DAT_DISCARD];
        end
    end

    // Control bits; soft reset clears them like a hard reset.
    always @(posedge clk) begin
        if (regs_rst) begin
            tx_enable_reg <= 1'b0;
            tx_stop_reg <= 1'b0;
            status_overrun_allow_reg <= 1'b0;
        end else begin
            if (wr_tx) begin
                status_overrun_allow_reg <= wdata[`TCR_TX_OVR_ALLOW];
            end
            // [RULE_05] Enable bit write.
            // [RULE_06] Auto clear on halt.
            if (stop_done) begin
                tx_enable_reg <= 1'b0;
            end else if (wr_tx) begin
                tx_enable_reg <= wdata[`TCR_TX_ENABLE];
            end
            // [RULE_07] Clear stop once halted.
            // [RULE_08] Writes ignored while set.
            if (tx_stop_reg) begin
                if (stop_done) begin
                    tx_stop_reg <= 1'b0;
                end
            end else if (wr_tx) begin
                tx_stop_reg <= wdata[`TCR_TX_STOP];
            end
        end
    end

    // ------------------------------------------------------------------
    // Hardware configuration register
    // ------------------------------------------------------------------
    // [RULE_12] Endian bits on hard reset only.
    always @(posedge clk) begin
        if (rst) begin
            port_endian_select_reg <= 1'b0;
            direct_endian_select_reg <= 1'b0;
        end else if (wr_hw) begin
            port_endian_select_reg <= wdata[`TCR_HW_PORT_END];
            direct_endian_select_reg <= wdata[`TCR_HW_DIR_END];
        end
    end

    // Other writable fields, set back to their reset values by either reset.
    always @(posedge clk) begin
        if (regs_rst) begin
            must_be_one_reg <= 1'b0;
            tx_alloc_size_reg <= `TCR_SIZE_RESET;
        end else if (wr_hw) begin
            must_be_one_reg <= wdata[`TCR_HW_MBO];
            // [RULE_15] Size within 2 to 14.
            // A reserved size would leave too little room on one side, so it is
            // dropped and the previous split stays in force.
            if (size_field >= `TCR_SIZE_MIN && size_field <= `TCR_SIZE_MAX) begin
                tx_alloc_size_reg <= size_field;
            end
        end
    end

    // The strap is taken once, so later pin changes or PHY overrides never show.
    // [RULE_13] Strap sampled after release.
    always @(posedge clk) begin
        if (rst) begin
            strap_taken_reg <= 1'b0;
            auto_crossover_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            auto_crossover_reg <= auto_crossover_strap;
        end
    end

    // ------------------------------------------------------------------
    // Memory split
    // ------------------------------------------------------------------
    // Transmit allocation in bytes: the size field counts whole kilobytes.
    assign alloc_bytes = {11'h000, tx_alloc_size_reg} << `TCR_KB_SHIFT;

    // Sizes are registered, so they follow a size change one cycle late.
    // [RULE_16] Status reserve.
    // [RULE_17] Receive remainder.
    always @(posedge clk) begin
        if (rst) begin
            tx_alloc_bytes_reg <= 15'h0000;
            tx_data_bytes_reg <= 15'h0000;
            rx_alloc_bytes_reg <= 15'h0000;
        end else begin
            tx_alloc_bytes_reg <= alloc_bytes;
            tx_data_bytes_reg <= alloc_bytes - `TCR_STS_BYTES;
            rx_alloc_bytes_reg <= `TCR_TOTAL_BYTES - alloc_bytes;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Unmapped addresses and cycles without a read strobe return zero.
    // [RULE_21] Reserved bits read zero.
    always @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= 32'h0000_0000;
            if (rd_stb && addr == `TCR_ADDR_TX_CFG) begin
                rdata_reg[`TCR_TX_OVR_ALLOW] <= status_overrun_allow_reg;
                rdata_reg[`TCR_TX_ENABLE] <= tx_enable_reg;
                rdata_reg[`TCR_TX_STOP] <= tx_stop_reg;
            end else if (rd_stb && addr == `TCR_ADDR_HARDWARE_CONFIG) begin
                rdata_reg[`TCR_HW_PORT_END] <= port_endian_select_reg;
                rdata_reg[`TCR_HW_DIR_END] <= direct_endian_select_reg;
                rdata_reg[`TCR_HW_XOVER] <= auto_crossover_reg;
                rdata_reg[`TCR_HW_MBO] <= must_be_one_reg;
                rdata_reg[`TCR_HW_SIZE_HI:`TCR_HW_SIZE_LO] <= tx_alloc_size_reg;
                rdata_reg[`TCR_HW_RST_TO] <= reset_timeout_flag;
                rdata_reg[`TCR_HW_SOFTWARE_RESET_BIT] <= software_reset_bit_busy;
            end
        end
    end

endmodule

// ==== testbench/tcr_regs_props.sv ====
// Assertion checker for the transmit and hardware configuration bank.
// Assumes it is bound to tcr_regs and sees only that module's ports.
module tcr_regs_props #(
    parameter SOFTWARE_RESET_BIT_TIMEOUT_CYC = 20
) (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [31:0] rdata_reg,
    input wire auto_crossover_strap,
    input wire phy_clocks_ok,
    input wire frame_active,
    input wire tx_status_full,
    input wire direct_fifo_sel,
    input wire tx_status_ptr_clear,
    input wire tx_data_ptr_clear,
    input wire tx_run,
    input wire tx_status_full_irq,
    input wire fifo_big_endian,
    input wire [14:0] tx_alloc_bytes_reg,
    input wire [14:0] tx_data_bytes_reg,
    input wire [14:0] rx_alloc_bytes_reg,
    input wire soft_reset_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Shadow state and properties
    // ----------------------------------------
    reg ovr_reg;
    // Follows the overrun allowance bit as last written by the host.
    always @(posedge clk) begin
        if (rst || soft_reset_out)
            ovr_reg <= 1'b0;
        else if (wr_stb && addr == 8'h70)
            ovr_reg <= wdata[2];
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sts_clear_pulse_a: assert property (
        tx_status_ptr_clear == $past(wr_stb && addr == 8'h70 && wdata[15]))
        else $error("status clear pulse wrong");
    dat_clear_pulse_a: assert property (
        tx_data_ptr_clear == $past(wr_stb && addr == 8'h70 && wdata[14]))
        else $error("data clear pulse wrong");
    full_suspends_a: assert property (
        !ovr_reg && tx_status_full && !frame_active |-> !tx_run)
        else $error("transmit not suspended on full status");
    irq_follows_full_a: assert property (
        tx_status_full_irq == tx_status_full)
        else $error("status full interrupt wrong");
    idle_after_reset_a: assert property (
        $fell(rst) |-> !tx_run && rdata_reg == 32'h0000_0000)
        else $error("transmit running after reset");
    reset_pulse_len_a: assert property (
        $rose(soft_reset_out) |-> ##15 soft_reset_out ##1 !soft_reset_out)
        else $error("soft reset pulse length wrong");
    reset_needs_clocks_a: assert property (
        $rose(soft_reset_out) |-> phy_clocks_ok)
        else $error("soft reset ran without link clocks");
    endian_keep_a: assert property (
        $past(soft_reset_out) && $stable(direct_fifo_sel) && !$past(wr_stb) |->
        $stable(fifo_big_endian))
        else $error("endian order lost in soft reset");
    space_split_a: assert property (
        tx_alloc_bytes_reg != 15'h0000 |->
        {1'b0, tx_alloc_bytes_reg} + {1'b0, rx_alloc_bytes_reg} == 16'h4000 &&
        tx_data_bytes_reg == tx_alloc_bytes_reg - 15'h0200)
        else $error("memory split wrong");
    alloc_range_a: assert property (
        tx_alloc_bytes_reg != 15'h0000 |-> tx_alloc_bytes_reg[9:0] == 10'h000 &&
        tx_alloc_bytes_reg >= 15'h0800 && tx_alloc_bytes_reg <= 15'h3800)
        else $error("transmit allocation out of range");
    unmapped_zero_a: assert property (
        !$past(rd_stb && (addr == 8'h70 || addr == 8'h74)) |-> rdata_reg == 32'h0000_0000)
        else $error("read data not zero");
endmodule

bind tcr_regs tcr_regs_props #(.SOFTWARE_RESET_BIT_TIMEOUT_CYC(SOFTWARE_RESET_BIT_TIMEOUT_CYC)) u_props (.clk, .rst,
    .addr, .wdata, .wr_stb, .rd_stb, .rdata_reg, .auto_crossover_strap, .phy_clocks_ok,
    .frame_active, .tx_status_full, .direct_fifo_sel, .tx_status_ptr_clear,
    .tx_data_ptr_clear, .tx_run, .tx_status_full_irq, .fifo_big_endian,
    .tx_alloc_bytes_reg, .tx_data_bytes_reg, .rx_alloc_bytes_reg, .soft_reset_out);

// ==== testbench/tcr_tx_engine_model.sv ====
// Behavioural transmit engine that starts a frame whenever it is idle, tx_run is high and the request is high.
// Assumes tx_run from the register bank and a request level from the bench.
module tcr_tx_engine_model #(
    parameter FRAME_LEN = 30
) (
    input wire clk,
    input wire rst,
    input wire tx_run,
    input wire frame_req,
    output reg frame_active
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] left_reg;
    // Starts a frame when allowed; a started frame always runs to its end.
    always @(posedge clk) begin
        if (rst) begin
            frame_active <= 1'b0;
            left_reg <= 8'h00;
        end else if (frame_active) begin
            left_reg <= left_reg - 8'h01;
            if (left_reg == 8'h01)
                frame_active <= 1'b0;
        end else if (tx_run && frame_req) begin
            frame_active <= 1'b1;
            left_reg <= FRAME_LEN[7:0];
        end
    end
endmodule

// ==== testbench/tb_tx_and_hw_config_regs.sv ====
// Self-checking bench for the transmit and hardware configuration bank.
// Assumes the bank, its checker and the transmit engine model are compiled.
module tb_tx_and_hw_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0000_0000;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg auto_crossover_strap = 1'b1;
    reg phy_clocks_ok = 1'b1;
    reg tx_status_full = 1'b0;
    reg direct_fifo_sel = 1'b0;
    reg frame_req = 1'b0;
    reg [31:0] n, sz;
    integer bad_count = 0;
    integer total_checks = 0;
    integer cycles = 0;
    wire [31:0] rdata_reg;
    wire frame_active, tx_status_ptr_clear, tx_data_ptr_clear, tx_run;
    wire tx_status_full_irq, fifo_big_endian, soft_reset_out;
    wire [14:0] tx_alloc_bytes_reg, tx_data_bytes_reg, rx_alloc_bytes_reg;
    // Bank under test, with a short soft reset timeout.
    tcr_regs #(.SOFTWARE_RESET_BIT_TIMEOUT_CYC(20)) DUT (.clk, .rst, .addr, .wdata, .wr_stb, .rd_stb,
        .rdata_reg, .auto_crossover_strap, .phy_clocks_ok, .frame_active, .tx_status_full,
        .direct_fifo_sel, .tx_status_ptr_clear, .tx_data_ptr_clear, .tx_run,
        .tx_status_full_irq, .fifo_big_endian, .tx_alloc_bytes_reg, .tx_data_bytes_reg,
        .rx_alloc_bytes_reg, .soft_reset_out);
    // Transmit engine on the far side.
    tcr_tx_engine_model #(.FRAME_LEN(30)) u_engine (.clk, .rst, .tx_run, .frame_req,
        .frame_active);
    // ----------------------------------------
    // Clock, watchdog and access tasks
    // ----------------------------------------
    // Free-running 10 MHz clock.
    initial begin
        forever #50 clk = ~clk;
    end
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end
    // Compares a word and counts the outcome.
    task automatic chk_word(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t ns: word %h, expected %h", $time, got, exp);
            end
        end
    endtask
    // Compares a flag and counts the outcome.
    task automatic chk_bit(input got, input exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t ns: flag %b, expected %b", $time, got, exp);
            end
        end
    endtask
    // One-cycle register write.
    task automatic wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr_stb <= 1'b1;
            @(posedge clk);
            wr_stb <= 1'b0;
        end
    endtask
    // One-cycle register read; data is checked in the following cycle.
    task automatic rd_chk(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd_stb <= 1'b1;
            @(posedge clk);
            rd_stb <= 1'b0;
            @(negedge clk);
            chk_word(rdata_reg, exp);
        end
    endtask
    // Waits a bounded time for frame_active (sel high) or soft_reset_out to reach val.
    task automatic wait_for(input sel, input val);
        integer k;
        begin
            k = 0;
            while ((sel ? frame_active : soft_reset_out) !== val && k < 40) begin
                @(negedge clk);
                k = k + 1;
            end
            chk_bit(sel ? frame_active : soft_reset_out, val);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task end_sim;
        begin
            $display("checks %0d, mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        auto_crossover_strap <= 1'b0;
        rd_chk(8'h70, 32'h0000_0000);
        rd_chk(8'h74, 32'h0105_0000);
        rd_chk(8'h78, 32'h0000_0000);
        $display("reset test done");
        sz = 5;
        for (n = 1; n <= 15; n = n + 1) begin
            wr(8'h74, 32'h0010_0000 | (n << 16));
            if (n >= 2 && n <= 14)
                sz = n;
            rd_chk(8'h74, 32'h0110_0000 | (sz << 16));
            chk_word({17'h0, tx_alloc_bytes_reg}, sz << 10);
            chk_word({17'h0, tx_data_bytes_reg}, (sz << 10) - 512);
            chk_word({17'h0, rx_alloc_bytes_reg}, 16384 - (sz << 10));
        end
        wr(8'h74, 32'hCEF6_FFFE);
        rd_chk(8'h74, 32'h0116_0000);
        wr(8'h70, 32'hFFFF_3FF8);
        rd_chk(8'h70, 32'h0000_0000);
        $display("size test done");
        for (n = 0; n < 2; n = n + 1) begin
            wr(8'h70, 32'h0000_4000 << n);
            @(negedge clk);
            chk_bit(tx_data_ptr_clear, n == 0);
            chk_bit(tx_status_ptr_clear, n == 1);
            rd_chk(8'h70, 32'h0000_0000);
        end
        $display("discard test done");
        wr(8'h70, 32'h0000_0002);
        repeat (2) @(negedge clk);
        chk_bit(tx_run, 1'b1);
        @(posedge clk);
        tx_status_full <= 1'b1;
        @(negedge clk);
        chk_bit(tx_run, 1'b0);
        chk_bit(tx_status_full_irq, 1'b1);
        wr(8'h70, 32'h0000_0006);
        repeat (2) @(negedge clk);
        chk_bit(tx_run, 1'b1);
        chk_bit(tx_status_full_irq, 1'b1);
        @(posedge clk);
        tx_status_full <= 1'b0;
        @(negedge clk);
        chk_bit(tx_status_full_irq, 1'b0);
        @(posedge clk);
        frame_req <= 1'b1;
        wait_for(1'b1, 1'b1);
        @(posedge clk);
        frame_req <= 1'b0;
        wr(8'h70, 32'h0000_0007);
        rd_chk(8'h70, 32'h0000_0007);
        wr(8'h70, 32'h0000_0006);
        rd_chk(8'h70, 32'h0000_0007);
        wait_for(1'b1, 1'b0);
        rd_chk(8'h70, 32'h0000_0004);
        chk_bit(tx_run, 1'b0);
        wr(8'h70, 32'h0000_0003);
        rd_chk(8'h70, 32'h0000_0000);
        chk_bit(tx_run, 1'b0);
        $display("transmit test done");
        for (n = 0; n < 8; n = n + 1) begin
            wr(8'h74, {2'b00, n[1:0], 12'h016, 16'h0000});
            @(posedge clk);
            direct_fifo_sel <= n[2];
            @(negedge clk);
            chk_bit(fifo_big_endian, n[2] ? n[0] : n[1]);
        end
        $display("endian test done");
        @(posedge clk);
        phy_clocks_ok <= 1'b0;
        wr(8'h74, 32'h3016_0001);
        repeat (30) @(posedge clk);
        rd_chk(8'h74, 32'h3116_0002);
        @(posedge clk);
        phy_clocks_ok <= 1'b1;
        wr(8'h74, 32'h3016_0001);
        wait_for(1'b0, 1'b1);
        wait_for(1'b0, 1'b0);
        rd_chk(8'h74, 32'h3105_0000);
        rd_chk(8'h70, 32'h0000_0000);
        $display("soft reset test done");
        end_sim;
    end
endmodule
